//--- ucev_pkg.sv
// Package with the register map, field positions and carrier types of the control event block.
package ucev_pkg;

  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;
  localparam int NUM_EP = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_BUS_STATUS = 16'hff27;
  localparam logic [IDX_W-1:0] IDX_CTRL_STATUS = 16'hff28;
  localparam logic [IDX_W-1:0] IDX_BUS_CLEAR = 16'hff30;
  localparam logic [IDX_W-1:0] IDX_CTRL_CLEAR = 16'hff31;
  localparam logic [IDX_W-1:0] IDX_HALT_STATUS = 16'hff32;

  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  localparam int BIT_DECODE = 0;
  localparam int BIT_SETUP_SEEN = 1;
  localparam int BIT_STATUS_STAGE = 2;
  localparam int BIT_SUCCESS = 3;
  localparam int BIT_RX_DATA = 4;
  localparam int BIT_TX_DONE = 5;
  localparam int BIT_IN_NAK = 6;
  localparam int BIT_STALL = 0;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACCESS = 2'b10
  } ucev_apb_type;

  // One-cycle event pulses and levels from the USB function engine.
  typedef struct packed {
    logic stall_enter;
    logic set_feature_halt;
    logic halt_mask_req;
    logic setup_token;
    logic in_nak;
    logic tx_done;
    logic tx_buf_write;
    logic rx_data;
    logic rx_zero_len;
    logic rx_buf_read;
    logic rx_count_zero;
    logic status_stage;
    logic status_no_ack;
    logic status_done;
    logic null_pid0;
    logic setup_rx;
    logic setup_hw_handled;
    logic setup_buf_all_read;
    logic fw_ctrl_read;
    logic tx_buf_cleared;
  } ucev_events_type;

  typedef struct packed {
    ucev_apb_type phase;
    logic [7:0] ctrl;
    logic stall;
    logic halt_mask;
    logic nak_pend;
    logic [7:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic nak_clr;
    logic rdy_set;
  } ucev_state_type;

endpackage

//--- ucev_event_status.sv
// Stall event flag, endpoint-0 control event register and endpoint halt view behind APB.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps

// Summary of operation
// - Any endpoint entering stall, even firmware-forced, sets the stall flag and interrupts if the flag was clear.
// - Stall flag ignores clear-feature, set-interface, set-configuration and later SETUP tokens.
// - Endpoint-0 halt bit reads 0 from a masking request until a different SETUP.
// - Any change of the control event register raises the shared status interrupt.
// - The control event register is read-only and read as one byte.
// - Writing 0 to a clear register bit clears the matching status bit unless an event sets it in the same cycle.
// - Status-stage and success flags clear when the next SETUP token arrives.
// - Bit 6 sets when an endpoint-0 IN token is answered with NAK automatically.
// - Bit 5 sets when the host correctly receives endpoint-0 transmit data, even zero-length.
// - Bit 5 clears on the first firmware write to the endpoint-0 transmit buffer.
// - Bit 4 and read-ready set on good non-empty endpoint-0 OUT data.
// - Bit 4 clears when firmware reads the receive buffer and its count reaches zero.
// - Bit 3 sets on good status-stage completion or null data with PID 0.
// - Bit 2 sets when any control transfer advances to its status stage.
// - Bit 2 also sets without data-stage ACK; for a firmware control read, write NAK then clears after buffer clear.
// - Bit 1 sets when SETUP data is correctly received into the setup buffer.
// - A repeated SETUP handled by hardware leaves the decode flag unset.
// - Bit 0 sets for a firmware-decoded request and clears once the buffer is read.
// - The stall flag lives in the bus event register; writing 0 clears it.
// - A set-feature endpoint-halt request also sets the stall flag.
module ucev_event_status
  import ucev_pkg::*;
#(
  parameter int EP_COUNT = NUM_EP
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ucev_events_type usb_events,
  input wire logic [EP_COUNT-1:0] endpoint_halt,
  output logic usb_status_irq,
  output logic ep0_read_ready_set,
  output logic ep0_write_nak_clear
);

  if (EP_COUNT < 1 || EP_COUNT > 8)
  begin : g_bad_count
    $error("EP_COUNT must lie between 1 and 8");
  end

  ucev_state_type st_ff;
  ucev_state_type nxt_st;
  logic [IDX_W-1:0] idx;
  logic hit;
  logic wr_now;
  logic wr_bus_clr;
  logic wr_ctrl_clr;
  logic [7:0] ctrl_set;
  logic [7:0] ctrl_auto_clr;
  logic [7:0] ctrl_fw_clr;
  logic [7:0] halt_view;
  logic [7:0] ep_halt_byte;
  logic stall_set;

  assign idx = paddr[ADDR_W-1:2];
  assign hit = (paddr[1:0] == 2'b00) &&
    (idx == IDX_BUS_STATUS || idx == IDX_CTRL_STATUS || idx == IDX_BUS_CLEAR ||
     idx == IDX_CTRL_CLEAR || idx == IDX_HALT_STATUS);
  // A write lands only at the access edge and only through the low byte lane.
  assign wr_now = (st_ff.phase == APB_ACCESS) && psel && penable && pwrite && pstrb[0] &&
    !st_ff.err;
  assign wr_bus_clr = wr_now && (idx == IDX_BUS_CLEAR);
  assign wr_ctrl_clr = wr_now && (idx == IDX_CTRL_CLEAR);

  genvar gi;
  for (gi = 0; gi < 8; gi++)
  begin : g_halt
    if (gi < EP_COUNT)
    begin : g_used
      assign ep_halt_byte[gi] = endpoint_halt[gi];
    end
    else
    begin : g_unused
      assign ep_halt_byte[gi] = 1'b0;
    end
  end

  // The endpoint-0 halt bit is hidden while a standard or firmware request owns it.
  assign halt_view = {ep_halt_byte[7:1], ep_halt_byte[0] & ~st_ff.halt_mask};

  assign stall_set = usb_events.stall_enter || usb_events.set_feature_halt;

  always_comb
  begin
    ctrl_set = 8'h00;
    ctrl_set[BIT_IN_NAK] = usb_events.in_nak;
    ctrl_set[BIT_TX_DONE] = usb_events.tx_done;
    ctrl_set[BIT_RX_DATA] = usb_events.rx_data && !usb_events.rx_zero_len;
    ctrl_set[BIT_SUCCESS] = usb_events.status_done || usb_events.null_pid0;
    ctrl_set[BIT_STATUS_STAGE] = usb_events.status_stage || usb_events.status_no_ack;
    ctrl_set[BIT_SETUP_SEEN] = usb_events.setup_rx;
    ctrl_set[BIT_DECODE] = usb_events.setup_rx && !usb_events.setup_hw_handled;
    ctrl_auto_clr = 8'h00;
    ctrl_auto_clr[BIT_TX_DONE] = usb_events.tx_buf_write;
    ctrl_auto_clr[BIT_RX_DATA] = usb_events.rx_buf_read && usb_events.rx_count_zero;
    ctrl_auto_clr[BIT_SUCCESS] = usb_events.setup_token;
    ctrl_auto_clr[BIT_STATUS_STAGE] = usb_events.setup_token;
    ctrl_auto_clr[BIT_DECODE] = usb_events.setup_buf_all_read;
    ctrl_fw_clr = wr_ctrl_clr ? ~pwdata[7:0] : 8'h00;
  end

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.irq = 1'b0;
    nxt_st.nak_clr = 1'b0;
    nxt_st.rdy_set = ctrl_set[BIT_RX_DATA];
    // Sets are applied last so an event is never lost to a clear.
    nxt_st.ctrl = ((st_ff.ctrl & ~ctrl_auto_clr & ~ctrl_fw_clr) | ctrl_set) & 8'h7f;
    nxt_st.stall = (st_ff.stall & ~(wr_bus_clr & ~pwdata[BIT_STALL])) | stall_set;
    if (usb_events.halt_mask_req)
    begin
      nxt_st.halt_mask = 1'b1;
    end
    else if (usb_events.setup_token)
    begin
      nxt_st.halt_mask = 1'b0;
    end
    if (st_ff.nak_pend && usb_events.tx_buf_cleared)
    begin
      nxt_st.nak_clr = 1'b1;
      nxt_st.nak_pend = 1'b0;
    end
    if (usb_events.status_no_ack && usb_events.fw_ctrl_read)
    begin
      nxt_st.nak_pend = 1'b1;
    end
    nxt_st.irq = (nxt_st.ctrl != st_ff.ctrl) || (nxt_st.stall != st_ff.stall);
    case (st_ff.phase)
      APB_IDLE:
      begin
        if (psel && !penable)
        begin
          nxt_st.phase = APB_ACCESS;
          nxt_st.ready = 1'b1;
          nxt_st.err = !hit;
          nxt_st.rdata = RST_RDATA;
          if (!pwrite && hit)
          begin
            case (idx)
              IDX_BUS_STATUS: nxt_st.rdata = {7'h00, st_ff.stall};
              IDX_CTRL_STATUS: nxt_st.rdata = st_ff.ctrl;
              IDX_HALT_STATUS: nxt_st.rdata = halt_view;
              default: nxt_st.rdata = RST_RDATA;
            endcase
          end
        end
      end
      APB_ACCESS:
      begin
        if (psel && penable)
        begin
          nxt_st.phase = APB_IDLE;
          nxt_st.ready = 1'b0;
          nxt_st.err = 1'b0;
        end
      end
      default:
      begin
        nxt_st.phase = APB_IDLE;
        nxt_st.ready = 1'b0;
        nxt_st.err = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '{phase: APB_IDLE, ctrl: RST_CTRL_STATUS, rdata: RST_RDATA, default: 1'b0};
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
    end
  end

  // The read bus carries one byte; the upper lanes always read as zero.
  assign prdata = {24'h000000, st_ff.rdata};
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign usb_status_irq = st_ff.irq;
  assign ep0_read_ready_set = st_ff.rdy_set;
  assign ep0_write_nak_clear = st_ff.nak_clr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup_phase;
    clk_en && psel && !penable && (st_ff.phase == APB_IDLE);
  endsequence

  sequence s_nak_armed;
    clk_en && usb_events.status_no_ack && usb_events.fw_ctrl_read;
  endsequence

  // A mapped, aligned read setup; read data is captured from the state at this edge.
  sequence s_read_setup;
    clk_en && psel && !penable && !pwrite && hit && (st_ff.phase == APB_IDLE);
  endsequence

  // A cycle in which the engine neither sets nor clears any control event bit.
  sequence s_quiet_ctrl;
    clk_en && (ctrl_set == 8'h00) && (ctrl_auto_clr == 8'h00);
  endsequence

  // A stall event on a flag that is already set changes nothing, so no new interrupt is due.
  a_stall_sets: assert property (clk_en && stall_set && !st_ff.stall |=> st_ff.stall && usb_status_irq)
    else $error("stall event did not set the stall flag with an interrupt");

  a_stall_no_auto: assert property (clk_en && st_ff.stall && !wr_bus_clr |=> st_ff.stall)
    else $error("stall flag cleared without a firmware clear");

  a_halt_masked: assert property (clk_en && usb_events.halt_mask_req |=> halt_view[0] == 1'b0)
    else $error("endpoint 0 halt bit visible while masked");

  a_irq_change: assert property ($changed({st_ff.ctrl, st_ff.stall}) |-> usb_status_irq)
    else $error("status change without interrupt");

  a_byte_read: assert property (s_setup_phase ##1 pready |-> prdata[31:8] == 24'h000000)
    else $error("read data beyond the low byte");

  a_fw_clear: assert property (clk_en && wr_ctrl_clr && !pwdata[BIT_IN_NAK] && !usb_events.in_nak
    |=> !st_ff.ctrl[BIT_IN_NAK])
    else $error("firmware clear did not clear the bit");

  a_setup_clears: assert property (clk_en && usb_events.setup_token && ctrl_set[3:2] == 2'b00
    |=> st_ff.ctrl[3:2] == 2'b00)
    else $error("setup token did not clear status stage and success");

  a_in_nak: assert property (clk_en && usb_events.in_nak |=> st_ff.ctrl[BIT_IN_NAK])
    else $error("IN NAK event lost");

  a_tx_clear: assert property (clk_en && usb_events.tx_buf_write && !usb_events.tx_done
    |=> !st_ff.ctrl[BIT_TX_DONE])
    else $error("transmit done not cleared by buffer write");

  a_rx_ready: assert property (clk_en && usb_events.rx_data && !usb_events.rx_zero_len
    |=> st_ff.ctrl[BIT_RX_DATA] && ep0_read_ready_set)
    else $error("receive data did not set flag and read ready");

  // Firmware may take many cycles to clear the buffer, so the release is checked from the
  // pending state rather than from the arming strobe one cycle earlier.
  a_nak_release: assert property (clk_en && st_ff.nak_pend && usb_events.tx_buf_cleared
    |=> ep0_write_nak_clear)
    else $error("write NAK not released after buffer clear");

  a_nak_armed: assert property (s_nak_armed |=> st_ff.nak_pend)
    else $error("write NAK release not armed");

  a_stall_bus_clr: assert property (clk_en && wr_bus_clr && !pwdata[BIT_STALL] && !stall_set
    |=> !st_ff.stall)
    else $error("stall flag not cleared by firmware write of zero");

  a_irq_stall_clr: assert property (clk_en && wr_bus_clr && !pwdata[BIT_STALL] && st_ff.stall &&
    !stall_set |=> usb_status_irq)
    else $error("stall flag clear without interrupt");

  a_stall_halt_req: assert property (clk_en && usb_events.set_feature_halt |=> st_ff.stall)
    else $error("set-feature halt did not set the stall flag");

  // Masking ends only on a token that does not itself restart it.
  a_mask_ends: assert property (clk_en && usb_events.setup_token && !usb_events.halt_mask_req
    |=> !st_ff.halt_mask)
    else $error("endpoint 0 halt mask not released by setup token");

  a_mask_holds: assert property (clk_en && st_ff.halt_mask && !usb_events.setup_token
    |=> st_ff.halt_mask)
    else $error("endpoint 0 halt mask dropped early");

  a_tx_done: assert property (clk_en && usb_events.tx_done |=> st_ff.ctrl[BIT_TX_DONE])
    else $error("transmit done event lost");

  a_rx_empty: assert property (clk_en && usb_events.rx_data && usb_events.rx_zero_len &&
    !st_ff.ctrl[BIT_RX_DATA] |=> !st_ff.ctrl[BIT_RX_DATA] && !ep0_read_ready_set)
    else $error("empty packet set the receive data flag");

  a_rx_ready_flag: assert property (ep0_read_ready_set |-> st_ff.ctrl[BIT_RX_DATA])
    else $error("read ready pulse without receive data flag");

  a_rx_clear: assert property (clk_en && usb_events.rx_buf_read && usb_events.rx_count_zero &&
    !ctrl_set[BIT_RX_DATA] |=> !st_ff.ctrl[BIT_RX_DATA])
    else $error("receive data flag not cleared by emptying read");

  a_success_set: assert property (clk_en && (usb_events.status_done || usb_events.null_pid0)
    |=> st_ff.ctrl[BIT_SUCCESS])
    else $error("success flag not set");

  a_stage_set: assert property (clk_en && (usb_events.status_stage || usb_events.status_no_ack)
    |=> st_ff.ctrl[BIT_STATUS_STAGE])
    else $error("status stage flag not set");

  a_setup_seen: assert property (clk_en && usb_events.setup_rx |=> st_ff.ctrl[BIT_SETUP_SEEN])
    else $error("setup seen flag not set");

  a_decode_set: assert property (clk_en && usb_events.setup_rx && !usb_events.setup_hw_handled
    |=> st_ff.ctrl[BIT_DECODE])
    else $error("decode request flag not set");

  a_decode_clear: assert property (clk_en && usb_events.setup_buf_all_read &&
    !usb_events.setup_rx |=> !st_ff.ctrl[BIT_DECODE])
    else $error("decode request flag not cleared after buffer read");

  // The status register is read-only, so a write to it must leave every bit alone.
  a_status_write: assert property (s_quiet_ctrl ##0 (wr_now && idx == IDX_CTRL_STATUS)
    |=> $stable(st_ff.ctrl))
    else $error("write to the status register changed it");

  // A clear write without the low byte lane carries no data and must be ignored.
  a_strb_masked: assert property (s_quiet_ctrl ##0 (psel && penable && pwrite && !pstrb[0] &&
    idx == IDX_CTRL_CLEAR) |=> $stable(st_ff.ctrl))
    else $error("clear write without byte lane took effect");

  a_irq_fw_clear: assert property (s_quiet_ctrl ##0 (wr_ctrl_clr &&
    (st_ff.ctrl & ~pwdata[7:0] & 8'h7f) != 8'h00) |=> usb_status_irq)
    else $error("firmware clear changed status without interrupt");

  a_bad_addr: assert property (s_setup_phase ##0 !hit |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  a_read_ctrl: assert property (s_read_setup ##0 (idx == IDX_CTRL_STATUS)
    |=> prdata[7:0] == $past(st_ff.ctrl))
    else $error("control status read returned a wrong value");

  a_read_halt: assert property (s_read_setup ##0 (idx == IDX_HALT_STATUS)
    |=> prdata[7:0] == $past(halt_view))
    else $error("halt status read returned a wrong value");

  a_read_stall: assert property (s_read_setup ##0 (idx == IDX_BUS_STATUS)
    |=> prdata[7:0] == {7'h00, $past(st_ff.stall)})
    else $error("bus status read returned a wrong value");

  // With the enable low every flop holds, so events in such a cycle are not seen at all.
  a_freeze: assert property (!clk_en |=> $stable(st_ff))
    else $error("state moved while the clock enable was low");

  a_hw_repeat: assert property (clk_en && usb_events.setup_rx && usb_events.setup_hw_handled &&
    !st_ff.ctrl[BIT_DECODE] |=> !st_ff.ctrl[BIT_DECODE] && st_ff.ctrl[BIT_SETUP_SEEN])
    else $error("decode flag set for hardware handled setup");

  a_top_zero: assert property (st_ff.ctrl[7] == 1'b0)
    else $error("top status bit set");

  a_set_wins: assert property (clk_en && wr_ctrl_clr && !pwdata[BIT_TX_DONE] &&
    usb_events.tx_done |=> st_ff.ctrl[BIT_TX_DONE])
    else $error("clear beat a same-cycle set");

  a_apb_ready: assert property (s_setup_phase |=> pready ##1 (!clk_en || !pready))
    else $error("APB answer not one access cycle");

endmodule

//--- ucev_usb_model.sv
// Behavioural stand-in for the USB function engine that strobes events into the block.
`timescale 1ns/1ps
module ucev_usb_model
  import ucev_pkg::*;
(
  input wire logic pclk,
  output ucev_events_type usb_events,
  output logic [NUM_EP-1:0] endpoint_halt
);
  initial
  begin
    usb_events = '0;
    endpoint_halt = '0;
  end

  // A real engine strobes each event for exactly one cycle, so the model never stretches one.
  task automatic send(input ucev_events_type e);
    usb_events <= e;
    @(posedge pclk);
    usb_events <= '0;
  endtask

  // Halt levels are live inputs of the block; the model alone drives them.
  task automatic set_halt(input logic [NUM_EP-1:0] h);
    endpoint_halt <= h;
  endtask
endmodule

//--- ucev_event_status_test.sv
// Self-checking bench for the control event status block.
`timescale 1ns/1ps
module ucev_event_status_test
  import ucev_pkg::*;
;
  logic pclk = 0;
  logic presetn = 0;
  logic clk_en = 1;
  logic [3:0] pstrb = 4'h1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic usb_status_irq;
  logic ep0_read_ready_set;
  logic ep0_write_nak_clear;
  ucev_events_type usb_events;
  logic [NUM_EP-1:0] endpoint_halt;
  logic [8:0] exp_q[$];
  int n_errors = 0;
  int n_compared = 0;

  always #5 pclk = ~pclk;

  ucev_usb_model i_ucev_usb_model (.pclk(pclk), .usb_events(usb_events),
    .endpoint_halt(endpoint_halt));

  ucev_event_status i_ucev_event_status (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .usb_events(usb_events), .endpoint_halt(endpoint_halt),
    .usb_status_irq(usb_status_irq), .ep0_read_ready_set(ep0_read_ready_set),
    .ep0_write_nak_clear(ep0_write_nak_clear));

  task automatic cmp(input logic [8:0] g, input logic [8:0] x);
    n_compared++;
    if (g !== x)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // The oldest note belongs to the transfer that completes now; writes expect no read data.
  always @(posedge pclk)
  begin
    if (psel && penable && pready)
      cmp({pslverr, pwrite ? 8'h00 : prdata[7:0]}, exp_q.pop_front());
  end

  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
    input logic [8:0] x);
    exp_q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= ($urandom() & 32'hffffff00) | {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [IDX_W-1:0] i, input logic [7:0] x);
    xfer(1'b0, {i, 2'b00}, 8'h00, {1'b0, x});
  endtask

  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
    xfer(1'b1, {i, 2'b00}, d, 9'h000);
  endtask

  // The mask is the packed event struct; s is the expected irq, read-ready and NAK-release.
  task automatic ev(input logic [19:0] m, input logic [7:0] x, input logic [2:0] s);
    i_ucev_usb_model.send(ucev_events_type'(m));
    @(posedge pclk);
    cmp({6'h00, usb_status_irq, ep0_read_ready_set, ep0_write_nak_clear}, {6'h00, s});
    rd(IDX_CTRL_STATUS, x);
  endtask

  task print_verdict;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #50us;
    n_errors++;
    $display("Error at %0t: run did not finish in time", $time);
    print_verdict;
  end

  initial
  begin
    void'($urandom(15));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_CTRL_STATUS, RST_CTRL_STATUS);
    rd(IDX_BUS_STATUS, 8'h00);
    ev(20'h08000, 8'h40, 3'b100);
    wr(IDX_CTRL_STATUS, 8'h00);
    rd(IDX_CTRL_STATUS, 8'h40);
    pstrb <= 4'h0;
    wr(IDX_CTRL_CLEAR, 8'h00);
    pstrb <= 4'h1;
    rd(IDX_CTRL_STATUS, 8'h40);
    wr(IDX_CTRL_CLEAR, 8'hbf);
    rd(IDX_CTRL_STATUS, 8'h00);
    ev(20'h04000, 8'h20, 3'b100);
    ev(20'h02000, 8'h00, 3'b100);
    ev(20'h01800, 8'h00, 3'b000);
    ev(20'h01000, 8'h10, 3'b110);
    ev(20'h00400, 8'h10, 3'b000);
    ev(20'h00600, 8'h00, 3'b100);
    ev(20'h00040, 8'h08, 3'b100);
    ev(20'h00100, 8'h0c, 3'b100);
    ev(20'h10000, 8'h00, 3'b100);
    ev(20'h00020, 8'h08, 3'b100);
    wr(IDX_CTRL_CLEAR, 8'hf7);
    rd(IDX_CTRL_STATUS, 8'h00);
    ev(20'h00018, 8'h02, 3'b100);
    ev(20'h00010, 8'h03, 3'b100);
    ev(20'h00004, 8'h02, 3'b100);
    wr(IDX_CTRL_CLEAR, 8'hfd);
    rd(IDX_CTRL_STATUS, 8'h00);
    ev(20'h00082, 8'h04, 3'b100);
    ev(20'h00001, 8'h04, 3'b001);
    ev(20'h10000, 8'h00, 3'b100);
    ev(20'h80000, 8'h00, 3'b100);
    rd(IDX_BUS_STATUS, 8'h01);
    ev(20'h10000, 8'h00, 3'b000);
    rd(IDX_BUS_STATUS, 8'h01);
    wr(IDX_BUS_CLEAR, 8'hfe);
    rd(IDX_BUS_STATUS, 8'h00);
    ev(20'h40000, 8'h00, 3'b100);
    rd(IDX_BUS_STATUS, 8'h01);
    i_ucev_usb_model.set_halt(3'b111);
    rd(IDX_HALT_STATUS, 8'h07);
    ev(20'h20000, 8'h00, 3'b000);
    rd(IDX_HALT_STATUS, 8'h06);
    ev(20'h10000, 8'h00, 3'b000);
    rd(IDX_HALT_STATUS, 8'h07);
    clk_en <= 1'b0;
    i_ucev_usb_model.send(ucev_events_type'(20'h08000));
    clk_en <= 1'b1;
    rd(IDX_CTRL_STATUS, 8'h00);
    xfer(1'b0, 18'h00000, 8'h00, 9'h100);
    xfer(1'b0, {IDX_CTRL_STATUS, 2'b01}, 8'h00, 9'h100);
    print_verdict;
  end
endmodule
